// file: rtl/efc_pkg.sv
package efc_pkg;

  // which force input the flop carries; one-hot, never clear and preset together
  typedef enum logic [2:0] {
    EFC_KIND_NONE   = 3'b001,
    EFC_KIND_CLEAR  = 3'b010,
    EFC_KIND_PRESET = 3'b100
  } efc_kind_e;

  // force_timing_style: act at once, or only on the active clock edge
  typedef enum logic [1:0] {
    EFC_STYLE_ASYNC = 2'b01,
    EFC_STYLE_SYNC  = 2'b10
  } efc_style_e;

  // power-up value choice: variant default, or forced zero / one
  typedef enum logic [2:0] {
    EFC_INIT_AUTO = 3'b001,
    EFC_INIT_ZERO = 3'b010,
    EFC_INIT_ONE  = 3'b100
  } efc_init_e;

  // user-side inputs, all from outside the clk domain
  typedef struct packed {
    logic flop_clk;
    logic data;
    logic enable;
    logic clear_low;
    logic preset_low;
  } efc_in_s;

  localparam int unsigned EFC_IN_W      = 5;
  // idle value: force inputs deasserted high, clock and data low
  localparam logic [4:0]  EFC_SYNC_RST  = 5'h03;
  localparam logic        EFC_INIT_PLAIN  = 1'b0;
  localparam logic        EFC_INIT_PRESET = 1'b1;
  localparam logic        EFC_EDGE_RISE = 1'b0;
  localparam logic        EFC_EDGE_FALL = 1'b1;

  // level that a force drives onto the output
  function automatic logic efc_force_value(input efc_kind_e kind);
    return (kind == EFC_KIND_PRESET) ? 1'b1 : 1'b0;
  endfunction

  // resolved power-up value for a variant
  function automatic logic efc_init_value(input efc_kind_e kind, input efc_init_e sel);
    logic v;
    v = EFC_INIT_PLAIN;
    unique case (sel)
      EFC_INIT_AUTO: v = (kind == EFC_KIND_PRESET) ? EFC_INIT_PRESET : EFC_INIT_PLAIN;
      EFC_INIT_ZERO: v = 1'b0;
      EFC_INIT_ONE:  v = 1'b1;
      default:       v = EFC_INIT_PLAIN;
    endcase
    return v;
  endfunction

endpackage

// file: rtl/efc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module efc_sync
  import efc_pkg::*;
(
  input  wire logic                clk,      // system clock
  input  wire logic                rst,      // sync reset, active high
  input  wire logic [EFC_IN_W-1:0] async_in, // raw pins
  output logic      [EFC_IN_W-1:0] sync_out  // two-flop synchronised copy
);
  logic [EFC_IN_W-1:0] meta_q;
  logic [EFC_IN_W-1:0] stab_q;

  // first stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= EFC_SYNC_RST;
      stab_q <= EFC_SYNC_RST;
    end else begin
      meta_q <= async_in;
      stab_q <= meta_q;
    end
  end

  assign sync_out = stab_q;
endmodule
`default_nettype wire

// file: rtl/efc_edge.sv
`timescale 1ns/1ps
`default_nettype none
module efc_edge
  import efc_pkg::*;
#(
  parameter logic FALL = EFC_EDGE_FALL // edge polarity to detect
) (
  input  wire logic clk,   // system clock
  input  wire logic rst,   // sync reset, active high
  input  wire logic level, // synchronised user clock
  output logic      pulse  // one-cycle active-edge strobe
);
  logic       prev_q;
  logic [2:0] primed_q;

  // gate held off until the synchroniser has flushed, so a user clock
  // that idles high at reset release gives no false rising edge
  always_ff @(posedge clk) begin
    if (rst) begin
      prev_q   <= 1'b0;
      primed_q <= 3'h0;
    end else begin
      prev_q   <= level;
      primed_q <= {primed_q[1:0], 1'b1};
    end
  end

  assign pulse = primed_q[2] & (FALL ? (prev_q & ~level) : (~prev_q & level));
endmodule
`default_nettype wire

// file: rtl/efc_flop.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// - plain falling variant copies data each edge
// - output starts at power-up value parameter
// - falling enable-preset variant defaults to one
// - load only while enable high, else hold
// - clear variant captures only when clear high
// - preset variant captures only when preset high
// - async clear forces zero at once
// - sync clear forces zero at falling edge
// - async preset forces one at once
// - sync preset forces one at falling edge
// - timing style selects async or edge-only clear
// - async style makes preset act immediately
// - timing style defaults to asynchronous
// - non-default init with async built in logic
// - rising enable-preset variant loads, preset forces high
// - rising sync preset forces one on edge
module efc_flop
  import efc_pkg::*;
#(
  parameter logic       EDGE_FALL          = EFC_EDGE_FALL,   // 1 falling, 0 rising
  parameter logic       HAS_ENABLE         = 1'b0,            // enable input used
  parameter efc_kind_e  FORCE_KIND         = EFC_KIND_NONE,   // none, clear or preset
  parameter efc_style_e FORCE_TIMING_STYLE = EFC_STYLE_ASYNC,
  parameter efc_init_e  POWERUP_SEL        = EFC_INIT_AUTO    // power-up value choice
) (
  input  wire logic             clk,        // system clock, 100 MHz
  input  wire logic             rst,        // sync reset, active high
  input  wire efc_pkg::efc_in_s user_in,    // flop clock, data, enable, clear, preset
  output logic                  q_out,      // flop output
  output logic                  forcing_out // clear or preset currently asserted
);
  import efc_pkg::*;

  localparam logic INIT_VAL  = efc_init_value(FORCE_KIND, POWERUP_SEL);
  localparam logic FORCE_VAL = efc_force_value(FORCE_KIND);
  localparam logic IS_ASYNC  = (FORCE_TIMING_STYLE == EFC_STYLE_ASYNC);

  efc_in_s s;
  logic    act_edge;
  logic    force_n;
  logic    load_en;
  logic    q_q;
  logic    forcing_q;

  efc_sync u_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in (user_in),
    .sync_out (s)
  );

  efc_edge #(
    .FALL (EDGE_FALL)
  ) u_edge (
    .clk   (clk),
    .rst   (rst),
    .level (s.flop_clk),
    .pulse (act_edge)
  );

  // only the force that the variant carries is looked at
  always_comb begin
    unique case (FORCE_KIND)
      EFC_KIND_CLEAR:  force_n = s.clear_low;
      EFC_KIND_PRESET: force_n = s.preset_low;
      default:         force_n = 1'b1;
    endcase
  end

  assign load_en = HAS_ENABLE ? s.enable : 1'b1;

  // generic logic, so any init and any style combine freely
  always_ff @(posedge clk) begin
    if (rst) begin
      q_q <= INIT_VAL;
    end else if (!force_n && IS_ASYNC) begin
      q_q <= FORCE_VAL;
    end else if (act_edge) begin
      if (!force_n) begin
        q_q <= FORCE_VAL;
      end else if (load_en) begin
        q_q <= s.data;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      forcing_q <= 1'b0;
    end else begin
      forcing_q <= ~force_n;
    end
  end

  assign q_out       = q_q;
  assign forcing_out = forcing_q;

  // helper: cycles since reset release, saturating
  logic [3:0] up_cnt_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      up_cnt_q <= 4'h0;
    end else if (up_cnt_q != 4'hF) begin
      up_cnt_q <= up_cnt_q + 4'h1;
    end
  end

  property p_plain_copy;
    @(posedge clk) disable iff (rst)
      (FORCE_KIND == EFC_KIND_NONE && !HAS_ENABLE && act_edge) |=> (q_out == $past(s.data));
  endproperty
  a_plain_copy: assert property (p_plain_copy)
    else $error("plain flop did not copy data on active edge");

  property p_init;
    @(posedge clk) rst |=> (q_out == INIT_VAL);
  endproperty
  a_init: assert property (p_init)
    else $error("output not at power-up value after reset");

  property p_preset_init;
    @(posedge clk) (rst && FORCE_KIND == EFC_KIND_PRESET && POWERUP_SEL == EFC_INIT_AUTO)
      |=> q_out;
  endproperty
  a_preset_init: assert property (p_preset_init)
    else $error("preset variant did not power up high");

  property p_hold_disabled;
    @(posedge clk) disable iff (rst)
      (HAS_ENABLE && force_n && !s.enable) |=> $stable(q_out);
  endproperty
  a_hold_disabled: assert property (p_hold_disabled)
    else $error("output changed while enable low");

  property p_load_enabled;
    @(posedge clk) disable iff (rst)
      (act_edge && force_n && load_en) |=> (q_out == $past(s.data));
  endproperty
  a_load_enabled: assert property (p_load_enabled)
    else $error("enabled capture with force high did not load data");

  property p_no_edge_hold;
    @(posedge clk) disable iff (rst)
      (!act_edge && (force_n || !IS_ASYNC)) |=> $stable(q_out);
  endproperty
  a_no_edge_hold: assert property (p_no_edge_hold)
    else $error("output moved without active edge or async force");

  property p_async_clear;
    @(posedge clk) disable iff (rst)
      (FORCE_KIND == EFC_KIND_CLEAR && IS_ASYNC && !user_in.clear_low)[*3] |=> !q_out;
  endproperty
  a_async_clear: assert property (p_async_clear)
    else $error("async clear did not force zero");

  property p_sync_clear;
    @(posedge clk) disable iff (rst)
      (FORCE_KIND == EFC_KIND_CLEAR && !IS_ASYNC && !force_n && act_edge) |=> !q_out;
  endproperty
  a_sync_clear: assert property (p_sync_clear)
    else $error("sync clear did not force zero on edge");

  property p_async_preset;
    @(posedge clk) disable iff (rst)
      (FORCE_KIND == EFC_KIND_PRESET && IS_ASYNC && !force_n) |=> q_out ##1 (q_out || force_n);
  endproperty
  a_async_preset: assert property (p_async_preset)
    else $error("async preset did not force one");

  property p_sync_preset;
    @(posedge clk) disable iff (rst)
      (FORCE_KIND == EFC_KIND_PRESET && !IS_ASYNC && !force_n && act_edge) |=> q_out;
  endproperty
  a_sync_preset: assert property (p_sync_preset)
    else $error("sync preset did not force one on edge");

  property p_sync_wait;
    @(posedge clk) disable iff (rst)
      (!IS_ASYNC && !force_n && !act_edge) |=> $stable(q_out);
  endproperty
  a_sync_wait: assert property (p_sync_wait)
    else $error("sync force acted without an edge");

  property p_forcing_flag;
    @(posedge clk) disable iff (rst)
      (up_cnt_q > 4'h2) |-> (forcing_out == !$past(force_n));
  endproperty
  a_forcing_flag: assert property (p_forcing_flag)
    else $error("forcing flag does not follow force input");

  property p_rise_load;
    @(posedge clk) disable iff (rst)
      (!EDGE_FALL && act_edge && force_n && load_en) |=> (q_out == $past(s.data));
  endproperty
  a_rise_load: assert property (p_rise_load)
    else $error("rising variant did not load data on its edge");

  property p_rise_sync_preset;
    @(posedge clk) disable iff (rst)
      (!EDGE_FALL && FORCE_KIND == EFC_KIND_PRESET && !IS_ASYNC && !force_n && act_edge)
        |=> q_out;
  endproperty
  a_rise_sync_preset: assert property (p_rise_sync_preset)
    else $error("rising sync preset did not force one on edge");

  property p_clear_blocks_load;
    @(posedge clk) disable iff (rst)
      (FORCE_KIND == EFC_KIND_CLEAR && !force_n && act_edge) |=> !q_out;
  endproperty
  a_clear_blocks_load: assert property (p_clear_blocks_load)
    else $error("data captured while clear held low");

  property p_preset_blocks_load;
    @(posedge clk) disable iff (rst)
      (FORCE_KIND == EFC_KIND_PRESET && !force_n && act_edge) |=> q_out;
  endproperty
  a_preset_blocks_load: assert property (p_preset_blocks_load)
    else $error("data captured while preset held low");

  property p_async_preset_pin;
    @(posedge clk) disable iff (rst)
      (FORCE_KIND == EFC_KIND_PRESET && IS_ASYNC && !user_in.preset_low)[*3] |=> q_out;
  endproperty
  a_async_preset_pin: assert property (p_async_preset_pin)
    else $error("async preset pin did not force one in time");

  property p_default_async;
    @(posedge clk) disable iff (rst)
      (FORCE_TIMING_STYLE == EFC_STYLE_ASYNC && !force_n && !act_edge)
        |=> (q_out == FORCE_VAL);
  endproperty
  a_default_async: assert property (p_default_async)
    else $error("async style force waited for an edge");

  property p_init_zero;
    @(posedge clk)
      (rst && FORCE_KIND == EFC_KIND_PRESET && IS_ASYNC && POWERUP_SEL == EFC_INIT_ZERO)
        |=> !q_out;
  endproperty
  a_init_zero: assert property (p_init_zero)
    else $error("async preset flop with zero init not low after reset");

  property p_forcing_reset;
    @(posedge clk)
      rst |=> !forcing_out;
  endproperty
  a_forcing_reset: assert property (p_forcing_reset)
    else $error("forcing flag set during reset");

  property p_act_edge_dir;
    @(posedge clk) disable iff (rst)
      act_edge |-> (s.flop_clk == !EDGE_FALL);
  endproperty
  a_act_edge_dir: assert property (p_act_edge_dir)
    else $error("edge strobe in the wrong direction");

  property p_edge_latency;
    @(posedge clk) disable iff (rst)
      (EDGE_FALL ? $fell(user_in.flop_clk) : $rose(user_in.flop_clk)) |-> ##2 act_edge;
  endproperty
  a_edge_latency: assert property (p_edge_latency)
    else $error("user clock edge not seen two cycles later");

  property p_enable_ignored;
    @(posedge clk) disable iff (rst)
      (!HAS_ENABLE && act_edge && force_n) |=> (q_out == $past(s.data));
  endproperty
  a_enable_ignored: assert property (p_enable_ignored)
    else $error("flop without enable did not load on edge");

  property p_forcing_pin;
    @(posedge clk) disable iff (rst)
      (FORCE_KIND == EFC_KIND_CLEAR && !user_in.clear_low)[*3] |=> forcing_out;
  endproperty
  a_forcing_pin: assert property (p_forcing_pin)
    else $error("forcing flag did not follow low clear pin");

  property p_change_cause;
    @(posedge clk) disable iff (rst)
      $changed(q_out) |-> ($past(act_edge) || (IS_ASYNC && !$past(force_n)));
  endproperty
  a_change_cause: assert property (p_change_cause)
    else $error("output changed without edge or async force");

  property p_force_wins;
    @(posedge clk) disable iff (rst)
      (FORCE_KIND != EFC_KIND_NONE && act_edge && !force_n && load_en) |=> (q_out == FORCE_VAL);
  endproperty
  a_force_wins: assert property (p_force_wins)
    else $error("load beat the force on the same edge");

  property p_async_clear_now;
    @(posedge clk) disable iff (rst)
      (FORCE_KIND == EFC_KIND_CLEAR && IS_ASYNC && !force_n) |=> !q_out;
  endproperty
  a_async_clear_now: assert property (p_async_clear_now)
    else $error("async clear did not hold output low");

  c_edge_load: cover property (@(posedge clk) disable iff (rst)
    act_edge && force_n && load_en && (s.data != q_q));
  c_force: cover property (@(posedge clk) disable iff (rst) !force_n ##1 force_n);
  c_hold: cover property (@(posedge clk) disable iff (rst) act_edge && !load_en && force_n);
  c_async_force: cover property (@(posedge clk) disable iff (rst)
    IS_ASYNC && !force_n && act_edge);
  c_rise_load: cover property (@(posedge clk) disable iff (rst)
    !EDGE_FALL && act_edge && load_en && force_n);
endmodule
`default_nettype wire

// file: verification/efc_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import efc_pkg::*;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  efc_in_s    pin = EFC_SYNC_RST;
  logic [7:0] q_vec;
  logic [7:0] exp_q[$];
  logic [5:0] m_q;
  int         error_cnt = 0;
  int         n_checks = 0;

  always #5 clk = ~clk;

  // a: fall/en/clear/sync, b: fall/en/preset/async, c: rise/en/preset/sync, d: plain, e: b at init 0
  efc_flop #(.HAS_ENABLE(1'b1), .FORCE_KIND(EFC_KIND_CLEAR), .FORCE_TIMING_STYLE(EFC_STYLE_SYNC))
    uut (.clk(clk), .rst(rst), .user_in(pin), .q_out(q_vec[6]), .forcing_out(q_vec[1]));
  efc_flop #(.HAS_ENABLE(1'b1), .FORCE_KIND(EFC_KIND_PRESET))
    uut_b (.clk(clk), .rst(rst), .user_in(pin), .q_out(q_vec[5]), .forcing_out(q_vec[0]));
  efc_flop #(.EDGE_FALL(EFC_EDGE_RISE), .HAS_ENABLE(1'b1), .FORCE_KIND(EFC_KIND_PRESET),
    .FORCE_TIMING_STYLE(EFC_STYLE_SYNC))
    uut_c (.clk(clk), .rst(rst), .user_in(pin), .q_out(q_vec[4]), .forcing_out());
  efc_flop uut_d (.clk(clk), .rst(rst), .user_in(pin), .q_out(q_vec[3]), .forcing_out());
  efc_flop #(.HAS_ENABLE(1'b1), .FORCE_KIND(EFC_KIND_PRESET), .POWERUP_SEL(EFC_INIT_ZERO))
    uut_e (.clk(clk), .rst(rst), .user_in(pin), .q_out(q_vec[2]), .forcing_out());
  // f: fall/en/clear/async
  efc_flop #(.HAS_ENABLE(1'b1), .FORCE_KIND(EFC_KIND_CLEAR))
    uut_f (.clk(clk), .rst(rst), .user_in(pin), .q_out(q_vec[7]), .forcing_out());

  task automatic cmp(input string nm, input logic [7:0] ex, input logic [7:0] got);
    n_checks++;
    if (got !== ex) begin
      error_cnt++;
      $display("wrong value %s expected %b seen %b", nm, ex, got);
    end
  endtask

  // pins settle 3 cycles before the user edge and hold 4 after, past the sync latency
  task automatic step(input logic d, input logic e, input logic cl, input logic pr,
                      input logic fc);
    logic rise;
    logic fall;
    @(negedge clk);
    pin.data = d;
    pin.enable = e;
    pin.clear_low = cl;
    pin.preset_low = pr;
    repeat (3) @(negedge clk);
    rise = !pin.flop_clk && fc;
    fall = pin.flop_clk && !fc;
    pin.flop_clk = fc;
    repeat (4) @(negedge clk);
    if (fall) m_q[4] = cl ? (e ? d : m_q[4]) : 1'b0;
    m_q[5] = !cl ? 1'b0 : ((fall && e) ? d : m_q[5]);
    if (!pr) begin
      m_q[3] = 1'b1;
      m_q[0] = 1'b1;
    end else if (fall && e) begin
      m_q[3] = d;
      m_q[0] = d;
    end
    if (rise) m_q[2] = pr ? (e ? d : m_q[2]) : 1'b1;
    if (fall) m_q[1] = d;
    exp_q.push_back({m_q, !cl, !pr});
  endtask

  always @(negedge clk) begin
    if (exp_q.size() > 0) cmp("q_and_forcing", exp_q.pop_front(), q_vec);
  end

  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    void'($urandom(73));
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    m_q = 6'h0C;
    @(negedge clk);
    exp_q.push_back({m_q, 2'b00});
    step(1'b0, 1'b1, 1'b1, 1'b1, 1'b1);
    step(1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
    step(1'b0, 1'b1, 1'b1, 1'b1, 1'b1);
    step(1'b0, 1'b1, 1'b1, 1'b1, 1'b0);
    // forces with no user edge: async flops move, sync ones wait
    step(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    step(1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
    step(1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
    step(1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
    step(1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
    repeat (60) begin
      step(1'($urandom % 2), 1'($urandom % 2), 1'($urandom % 4 != 0), 1'($urandom % 4 != 0),
           ($urandom % 4 != 0) ? !pin.flop_clk : pin.flop_clk);
    end
    repeat (3) @(negedge clk);
    summarize();
  end
endmodule
`default_nettype wire
